// ===== rtl/dcc_crc.sv
// Summary of operation
// - headers carry 16-bit code, checked identically
// - single-register data uses 16-bit code
// - multi-register data uses 32-bit code
// - register seeded all ones before field
// - input bit xor register top bit
// - zero result: shift left only
// - one result: shift left, xor polynomial
// - short generator mask 0x1021
// - long generator mask 0x04C11DB7, same loop
// - codes give Hamming distance four
// - register after last bit is code
// - bytes fed msb first, unreflected
// - no final inversion applied
`timescale 1ns/1ps
`default_nettype none
module dcc_crc (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic start_in,
   input wire logic multi_reg_in,
   input wire logic header_in,
   input wire logic byte_valid_in,
   input wire logic [7:0] byte_in,
   input wire logic end_in,
   input wire logic check_in,
   input wire logic [31:0] rx_crc_in,
   output logic byte_ready_out,
   output logic [31:0] crc_out,
   output logic long_out,
   output logic done_out,
   output logic crc_err_out
);
   import dcc_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   dcc_state_t state_r, state_nxt;
   dcc_sel_t sel_r, sel_nxt;
   logic [31:0] crc_r, crc_nxt;
   logic [7:0] sh_r, sh_nxt;
   logic [2:0] cnt_r, cnt_nxt;
   logic last_r, last_nxt;
   logic check_r, check_nxt;
   logic [31:0] rx_r, rx_nxt;
   logic rdy_r, rdy_nxt;
   logic done_r, done_nxt;
   logic err_r, err_nxt;
   logic [31:0] out_r, out_nxt;
   logic [31:0] step_crc;
   logic [31:0] final_crc;

   dcc_step u_step (
      .crc_in(crc_r),
      .bit_in(sh_r[7]),
      .long_in(sel_r == DCC_SEL_LONG),
      .crc_out(step_crc)
   );

   // result masked to width; xor-out is zero so nothing inverts
   always_comb begin
      if (sel_r == DCC_SEL_LONG) begin
         final_crc = step_crc ^ DCC_XOR_OUT;
      end else begin
         final_crc = {16'h0000, step_crc[15:0] ^ DCC_XOR_OUT[15:0]};
      end
   end

   // ************************************************************
   // next-state: one bit per clock, byte taken when idle-ready
   // ************************************************************
   always_comb begin
      state_nxt = state_r;
      sel_nxt = sel_r;
      crc_nxt = crc_r;
      sh_nxt = sh_r;
      cnt_nxt = cnt_r;
      last_nxt = last_r;
      check_nxt = check_r;
      rx_nxt = rx_r;
      rdy_nxt = rdy_r;
      done_nxt = 1'b0;
      err_nxt = err_r;
      out_nxt = out_r;
      if (start_in) begin
         // header or single register: short; multi register: long
         if (!header_in && multi_reg_in) begin
            sel_nxt = DCC_SEL_LONG;
            crc_nxt = DCC_LONG_INIT;
         end else begin
            sel_nxt = DCC_SEL_SHORT;
            crc_nxt = {16'h0000, DCC_SHORT_INIT};
         end
         state_nxt = DCC_IDLE;
         rdy_nxt = 1'b1;
         err_nxt = 1'b0;
      end else begin
         case (state_r)
            DCC_IDLE: begin
               if (byte_valid_in && rdy_r) begin
                  sh_nxt = byte_in;
                  cnt_nxt = DCC_FIRST_BIT;
                  last_nxt = end_in;
                  check_nxt = check_in;
                  rx_nxt = rx_crc_in;
                  rdy_nxt = 1'b0;
                  state_nxt = DCC_SHIFT;
               end
            end
            DCC_SHIFT: begin
               crc_nxt = step_crc;
               sh_nxt = {sh_r[6:0], 1'b0};
               cnt_nxt = cnt_r + 3'h1;
               if (cnt_r == DCC_LAST_BIT) begin
                  if (last_r) begin
                     state_nxt = DCC_DONE;
                     out_nxt = final_crc;
                     done_nxt = 1'b1;
                     // compare only the active width
                     if (check_r) begin
                        err_nxt = (sel_r == DCC_SEL_LONG)
                           ? (final_crc != rx_r)
                           : (final_crc[15:0] != rx_r[15:0]);
                     end
                  end else begin
                     state_nxt = DCC_IDLE;
                     rdy_nxt = 1'b1;
                  end
               end
            end
            default: begin
               // wait for next start; bytes refused here
               rdy_nxt = 1'b0;
            end
         endcase
      end
   end

   // register only
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_r <= DCC_DONE;
         sel_r <= DCC_SEL_SHORT;
         crc_r <= 32'h00000000;
         sh_r <= 8'h00;
         cnt_r <= 3'h0;
         last_r <= 1'b0;
         check_r <= 1'b0;
         rx_r <= 32'h00000000;
         rdy_r <= 1'b0;
         done_r <= 1'b0;
         err_r <= 1'b0;
         out_r <= 32'h00000000;
      end else begin
         state_r <= state_nxt;
         sel_r <= sel_nxt;
         crc_r <= crc_nxt;
         sh_r <= sh_nxt;
         cnt_r <= cnt_nxt;
         last_r <= last_nxt;
         check_r <= check_nxt;
         rx_r <= rx_nxt;
         rdy_r <= rdy_nxt;
         done_r <= done_nxt;
         err_r <= err_nxt;
         out_r <= out_nxt;
      end
   end

   assign byte_ready_out = rdy_r;
   assign crc_out = out_r;
   assign long_out = (sel_r == DCC_SEL_LONG);
   assign done_out = done_r;
   assign crc_err_out = err_r;

   // ************************************************************
   // assertions
   // ************************************************************
   sequence s_short_start;
      start_in && (header_in || !multi_reg_in);
   endsequence
   sequence s_long_start;
      start_in && !header_in && multi_reg_in;
   endsequence

   property p_short_seed;
      @(posedge ref_clk_in) disable iff (rst_in)
      s_short_start |=> crc_r == 32'h0000FFFF && !long_out;
   endproperty
   a_short_seed: assert property (p_short_seed)
      else $error("short code not seeded with ones");

   property p_long_seed;
      @(posedge ref_clk_in) disable iff (rst_in)
      s_long_start |=> crc_r == 32'hFFFFFFFF && long_out;
   endproperty
   a_long_seed: assert property (p_long_seed)
      else $error("long code not seeded with ones");

   property p_shift_zero;
      @(posedge ref_clk_in) disable iff (rst_in)
      (state_r == DCC_SHIFT && !start_in && long_out
       && (sh_r[7] == crc_r[31]))
      |=> crc_r == ($past(crc_r) << 1);
   endproperty
   a_shift_zero: assert property (p_shift_zero)
      else $error("zero feedback did more than shift");

   property p_shift_one;
      @(posedge ref_clk_in) disable iff (rst_in)
      (state_r == DCC_SHIFT && !start_in && long_out
       && (sh_r[7] != crc_r[31]))
      |=> crc_r == (($past(crc_r) << 1) ^ DCC_LONG_POLY);
   endproperty
   a_shift_one: assert property (p_shift_one)
      else $error("long feedback did not apply mask");

   property p_short_one;
      @(posedge ref_clk_in) disable iff (rst_in)
      (state_r == DCC_SHIFT && !start_in && !long_out
       && (sh_r[7] != crc_r[15]))
      |=> crc_r == ((($past(crc_r) << 1) & 32'h0000FFFF) ^ 32'h00001021);
   endproperty
   a_short_one: assert property (p_short_one)
      else $error("short feedback did not apply mask");

   // short code with zero feedback: plain shift, top half stays clear
   property p_short_zero;
      @(posedge ref_clk_in) disable iff (rst_in)
      (state_r == DCC_SHIFT && !start_in && !long_out
       && (sh_r[7] == crc_r[15]))
      |=> crc_r == (($past(crc_r) << 1) & 32'h0000FFFF);
   endproperty
   a_short_zero: assert property (p_short_zero)
      else $error("short zero feedback did more than shift");

   property p_err;
      @(posedge ref_clk_in) disable iff (rst_in)
      done_out && check_r && !long_out
      |-> crc_err_out == (crc_out[15:0] != rx_r[15:0]);
   endproperty
   a_err: assert property (p_err)
      else $error("error flag disagrees with compare");

   property p_byte_len;
      @(posedge ref_clk_in) disable iff (rst_in)
      (state_r == DCC_IDLE && byte_valid_in && rdy_r && !start_in)
      ##1 (!start_in) [*8] |=> state_r != DCC_SHIFT;
   endproperty
   a_byte_len: assert property (p_byte_len)
      else $error("byte did not finish in eight steps");

   property p_done_hold;
      @(posedge ref_clk_in) disable iff (rst_in)
      done_out |-> state_r == DCC_DONE && !byte_ready_out;
   endproperty
   a_done_hold: assert property (p_done_hold)
      else $error("done raised outside final state");
endmodule
`default_nettype wire

// ===== rtl/dcc_pkg.sv
package dcc_pkg;
   // ************************************************************
   // widths, seeds and generator masks
   // ************************************************************
   localparam int DCC_SHORT_W = 16;
   localparam int DCC_LONG_W = 32;
   localparam int DCC_BYTE_W = 8;
   localparam logic [15:0] DCC_SHORT_INIT = 16'hFFFF;
   localparam logic [31:0] DCC_LONG_INIT = 32'hFFFFFFFF;
   localparam logic [15:0] DCC_SHORT_POLY = 16'h1021;
   localparam logic [31:0] DCC_LONG_POLY = 32'h04C11DB7;
   localparam logic [31:0] DCC_XOR_OUT = 32'h00000000;
   localparam logic [2:0] DCC_LAST_BIT = 3'h7;
   localparam logic [2:0] DCC_FIRST_BIT = 3'h0;

   // code width selection made at field start
   typedef enum logic {
      DCC_SEL_SHORT,
      DCC_SEL_LONG
   } dcc_sel_t;

   // engine state
   typedef enum logic [1:0] {
      DCC_IDLE,
      DCC_SHIFT,
      DCC_DONE
   } dcc_state_t;
endpackage

// ===== rtl/dcc_step.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// one serial step of the check register
// ************************************************************
module dcc_step (
   input wire logic [31:0] crc_in,
   input wire logic bit_in,
   input wire logic long_in,
   output logic [31:0] crc_out
);
   import dcc_pkg::*;
   logic fb_short;
   logic fb_long;
   logic [15:0] sh_short;
   // feedback is data bit xor current top bit; short code lives in [15:0]
   always_comb begin
      fb_short = bit_in ^ crc_in[15];
      fb_long = bit_in ^ crc_in[31];
      sh_short = {crc_in[14:0], 1'b0};
      if (long_in) begin
         crc_out = fb_long ? ({crc_in[30:0], 1'b0} ^ DCC_LONG_POLY)
                           : {crc_in[30:0], 1'b0};
      end else begin
         crc_out = {16'h0000,
                    fb_short ? (sh_short ^ DCC_SHORT_POLY) : sh_short};
      end
   end
endmodule
`default_nettype wire

// ===== testbench/dcc_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// far side: host or neighbour building the same check codes
// ************************************************************
module dcc_peer;
   // plain bitwise loop, one byte after another
   function automatic logic [31:0] code(input logic [7:0] b [9],
      input int n, input bit lng);
      logic [31:0] r;
      logic fb;
      r = lng ? 32'hFFFFFFFF : 32'h0000FFFF;
      for (int i = 0; i < n; i++) begin
         for (int k = 7; k >= 0; k--) begin // msb first
            fb = b[i][k] ^ (lng ? r[31] : r[15]);
            r = r << 1;
            if (fb) begin
               r = r ^ (lng ? 32'h04C11DB7 : 32'h00001021);
            end
         end
      end
      // short code lives in the low half only
      if (!lng) begin
         r[31:16] = 16'h0000;
      end
      return r; // no final inversion
   endfunction
endmodule
`default_nettype wire

// ===== testbench/test_daisy_chain_packet_crc.sv
`timescale 1ns/1ps
`default_nettype none
module test_daisy_chain_packet_crc;
   import dcc_pkg::*;
   logic ref_clk_in, rst_in, start_in, multi_reg_in, header_in;
   logic byte_valid_in, end_in, check_in;
   logic [7:0] byte_in;
   logic [31:0] rx_crc_in, crc_out, flip;
   logic byte_ready_out, long_out, done_out, crc_err_out;
   logic [7:0] seed;
   logic [7:0] bq [9];
   int num_errors, compares;
   dcc_crc dcc_crc_inst(.ref_clk_in, .rst_in, .start_in, .multi_reg_in,
      .header_in, .byte_valid_in, .byte_in, .end_in, .check_in,
      .rx_crc_in, .byte_ready_out, .crc_out, .long_out, .done_out,
      .crc_err_out);
   dcc_peer dcc_peer_inst();
   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
      input string msg);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t %s: %h vs %h", $time, msg, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("compares %0d, errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // one field: start, bytes held until taken, then wait for done
   task automatic run_field(input bit hdr, input bit mul, input bit chk,
      input int n);
      logic [31:0] exp;
      bit lng;
      int k;
      lng = !hdr && mul;
      exp = dcc_peer_inst.code(bq, n, lng);
      start_in = 1'b1;
      header_in = hdr;
      multi_reg_in = mul;
      @(negedge ref_clk_in);
      start_in = 1'b0;
      for (int i = 0; i < n; i++) begin
         byte_in = bq[i];
         byte_valid_in = 1'b1;
         end_in = (i == n - 1);
         check_in = chk && (i == n - 1);
         rx_crc_in = exp ^ flip;
         k = 0;
         while (byte_ready_out !== 1'b1 && k < 50) begin
            @(negedge ref_clk_in);
            k++;
         end
         check(k, (i == 0) ? 0 : 8, "byte spacing");
         @(negedge ref_clk_in);
      end
      // valid stays up between bytes; released once after the last
      byte_valid_in = 1'b0;
      end_in = 1'b0;
      check_in = 1'b0;
      byte_in = ~byte_in;
      k = 1;
      while (done_out !== 1'b1 && k < 40) begin
         @(negedge ref_clk_in);
         k++;
      end
      check(k, 9, "done delay");
      check(crc_out, exp, "code");
      check(long_out, lng, "width");
      check(crc_err_out, chk && flip != 0, "error");
      $display("field of %0d bytes, long %0b done", n, lng);
   endtask
   // clock, 10 ns period
   initial begin
      ref_clk_in = 1'b0;
      forever #5 ref_clk_in = ~ref_clk_in;
   end
   // hang guard, far above the roughly 1800 cycles needed
   initial begin
      repeat (20000) @(posedge ref_clk_in);
      num_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      wrap_up();
   end
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      rst_in = 1'b1;
      {start_in, multi_reg_in, header_in} = 3'h0;
      {byte_valid_in, end_in, check_in} = 3'h0;
      byte_in = 8'h00;
      rx_crc_in = 32'h00000000;
      flip = 32'h00000000;
      num_errors = 0;
      compares = 0;
      seed = 8'h5A;
      repeat (8) @(negedge ref_clk_in);
      rst_in = 1'b0;
      for (int i = 0; i < 9; i++) begin
         bq[i] = 8'h31 + i[7:0];
      end
      run_field(1'b0, 1'b1, 1'b1, 9);
      check(crc_out, 32'h0376E6E7, "known code");
      // abort a long field mid-shift, the next start must reseed
      start_in = 1'b1;
      @(negedge ref_clk_in);
      {start_in, byte_valid_in} = 2'h1;
      repeat (2) @(negedge ref_clk_in);
      byte_valid_in = 1'b0;
      repeat (3) @(negedge ref_clk_in);
      check(byte_ready_out, 1'b0, "busy while shifting");
      check(done_out, 1'b0, "no done mid-field");
      check(crc_out, 32'h0376E6E7, "code held");
      $display("abort mid-field done");
      // every field kind, length and up to three corrupted bits
      for (int t = 0; t < 36; t++) begin
         flip = 32'h00000000;
         for (int i = 0; i < 9; i++) begin
            seed = lfsr(seed);
            bq[i] = seed;
         end
         for (int j = 0; j < t % 4; j++) begin
            seed = lfsr(seed);
            flip = flip | (32'h00000001 << seed[3:0]);
         end
         run_field(t % 3 == 0, t % 3 != 1, (t / 4) % 2 == 1, 1 + t % 9);
      end
      // host writes the cell selection word selecting positions six to nine
      flip = 32'h00000000;
      bq[0] = 8'h01;
      bq[1] = 8'hE0;
      run_field(1'b0, 1'b0, 1'b1, 2);
      wrap_up();
   end
endmodule
`default_nettype wire
